// ### adc_serial_seq.sv
// serial port sequencer of the converter: ready strobe, chip select,
// instruction and register data phases, data line drive and release
// assumes master_clock_in is the converter master clock; core side on
// core_clk supplies results and takes written words
`timescale 1ns/1ps
// Behaviour
// - master mode: generated serial clock high two and low two periods
// - master, select low: first rising edge twelve periods after ready
// - master: ten periods from instruction last fall to data rise
// - master: ready rises six periods after last data fall
// - slave: ready rises eight to ten periods after last data fall
// - master with select: first rising edge ten to twelve after select
// - master: data line released four periods after instruction
// - slave: data line released six to eight after instruction
// - read: data line driven four periods before first data rise
// - master: data line released two periods after last data fall
// - slave: data line released four to six after last data fall
// - result update blocked while output data register is being read
module adc_serial_seq (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // link clock
    input wire logic master_clock_in,
    // configuration
    input wire logic master_mode,
    // conversion results in
    input wire logic result_valid,
    input wire adc_serial_pkg::word_t result_word,
    // register data written by the host
    output logic write_valid,
    output adc_serial_pkg::word_t write_word,
    // serial pins
    input wire adc_serial_pkg::pin_in_t pins_in,
    output adc_serial_pkg::pin_out_t pins_out
);

    // link domain reset and synchronised inputs
    logic link_rst_b;
    adc_serial_pkg::pin_in_t pin_s;
    logic master_s;
    logic res_valid;
    adc_serial_pkg::word_t res_word;

    // sequencer state
    adc_serial_pkg::seq_state_t st_reg, st_next;
    adc_serial_pkg::cnt_t cnt_reg, cnt_next;
    adc_serial_pkg::cnt_t phase_reg, phase_next;
    adc_serial_pkg::cnt_t bit_reg, bit_next;
    adc_serial_pkg::cnt_t nbits_reg, nbits_next;
    adc_serial_pkg::cnt_t cs_lo_reg, cs_lo_next;
    adc_serial_pkg::cnt_t sync_lo_reg, sync_lo_next;
    logic [adc_serial_pkg::INSTR_BITS-1:0] instruction_byte_reg;
    logic [adc_serial_pkg::INSTR_BITS-1:0] instr_next;
    adc_serial_pkg::word_t output_data_register, dor_next;
    adc_serial_pkg::word_t shift_reg, shift_next;
    logic rd_reg, rd_next;
    logic sclk_reg, sclk_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic sdo_reg, sdo_next;
    logic oe_reg, oe_next;
    logic ready_n_reg, ready_n_next;
    logic wr_vld_reg, wr_vld_next;

    // decoded events
    logic running;
    logic m_tgl;
    logic rise;
    logic fall;
    logic rd_busy;
    logic sync_hold;
    logic [adc_serial_pkg::INSTR_BITS-1:0] instr_shift;

    // number of register data bits named by the instruction byte
    function automatic adc_serial_pkg::cnt_t data_bits(
        input logic [adc_serial_pkg::INSTR_BITS-1:0] ins
    );
        logic [adc_serial_pkg::INSTR_LEN_W-1:0] len;
        len = ins[adc_serial_pkg::INSTR_LEN_LSB +:
                  adc_serial_pkg::INSTR_LEN_W];
        data_bits = adc_serial_pkg::cnt_t'({len, 3'h0}) +
                    adc_serial_pkg::cnt_t'(adc_serial_pkg::INSTR_BITS);
    endfunction : data_bits

    // saturating count
    function automatic adc_serial_pkg::cnt_t cnt_inc(
        input adc_serial_pkg::cnt_t c
    );
        cnt_inc = (c == adc_serial_pkg::C_MAX) ? c :
                  adc_serial_pkg::cnt_t'(c + 6'h01);
    endfunction : cnt_inc

    level_sync #(.W(1)) u_rst_sync (
        .clk(master_clock_in),
        .d(rst_b),
        .q(link_rst_b)
    );

    // pins and mode level enter the link domain through two flops
    level_sync #(.W(5)) u_pin_sync (
        .clk(master_clock_in),
        .d({pins_in, master_mode}),
        .q({pin_s, master_s})
    );

    word_xfer u_result_xfer (
        .src_clk(core_clk),
        .src_rst_b(rst_b),
        .src_valid(result_valid),
        .src_word(result_word),
        .dst_clk(master_clock_in),
        .dst_rst_b(link_rst_b),
        .dst_valid(res_valid),
        .dst_word(res_word)
    );

    word_xfer u_write_xfer (
        .src_clk(master_clock_in),
        .src_rst_b(link_rst_b),
        .src_valid(wr_vld_reg),
        .src_word(shift_reg),
        .dst_clk(core_clk),
        .dst_rst_b(rst_b),
        .dst_valid(write_valid),
        .dst_word(write_word)
    );

    // whole sequencer runs on the master clock input
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_inc(cnt_reg);
        phase_next = cnt_inc(phase_reg);
        bit_next = bit_reg;
        nbits_next = nbits_reg;
        instr_next = instruction_byte_reg;
        dor_next = output_data_register;
        shift_next = shift_reg;
        rd_next = rd_reg;
        sclk_next = sclk_reg;
        sclk_prev_next = pin_s.sclk;
        sdo_next = sdo_reg;
        oe_next = oe_reg;
        ready_n_next = ready_n_reg;
        wr_vld_next = 1'b0;

        cs_lo_next = pin_s.cs_n ? 6'h00 : cnt_inc(cs_lo_reg);
        sync_lo_next = pin_s.sync_n ? 6'h00 : cnt_inc(sync_lo_reg);
        sync_hold = (sync_lo_reg >= adc_serial_pkg::C_SYNC_MIN);

        running = (st_reg == adc_serial_pkg::ST_INSTR) ||
                  (st_reg == adc_serial_pkg::ST_DATA);
        m_tgl = master_s && running && (phase_reg == adc_serial_pkg::C_HALF);
        if (master_s) begin
            rise = m_tgl && !sclk_reg;
            fall = m_tgl && sclk_reg;
        end else begin
            // host clock phases of five periods outlast the sync delay
            rise = running && pin_s.sclk && !sclk_prev_reg;
            fall = running && !pin_s.sclk && sclk_prev_reg;
        end
        if (m_tgl) begin
            sclk_next = ~sclk_reg;
            phase_next = 6'h00;
        end
        instr_shift = {instruction_byte_reg[adc_serial_pkg::INSTR_BITS-2:0],
                       pin_s.sdio};
        rd_busy = rd_reg && ((st_reg == adc_serial_pkg::ST_GAP) ||
                             (st_reg == adc_serial_pkg::ST_DATA));

        // new result lands unless the register is being shifted out
        if (res_valid && !rd_busy) begin
            dor_next = res_word;
        end

        case (st_reg)
            adc_serial_pkg::ST_IDLE: begin
                sclk_next = 1'b0;
                oe_next = 1'b0;
                if (res_valid) begin
                    ready_n_next = 1'b0;
                    cnt_next = 6'h00;
                    st_next = adc_serial_pkg::ST_WAIT;
                end
            end
            adc_serial_pkg::ST_WAIT: begin
                bit_next = 6'h00;
                instr_next = 8'h00;
                if (master_s) begin
                    // select tied low: ready term governs; else the later of the ready and select terms
                    if (cnt_reg >= adc_serial_pkg::C_RDY_FIRST &&
                        cs_lo_reg >= adc_serial_pkg::C_CS_FIRST) begin
                        sclk_next = 1'b1;
                        phase_next = 6'h00;
                        st_next = adc_serial_pkg::ST_INSTR;
                    end
                end else if (!pin_s.cs_n && pin_s.sclk && !sclk_prev_reg) begin
                    // host spacing after ready and select is trusted
                    st_next = adc_serial_pkg::ST_INSTR;
                end
            end
            adc_serial_pkg::ST_INSTR: begin
                if (fall) begin
                    instr_next = instr_shift;
                    bit_next = adc_serial_pkg::cnt_t'(bit_reg + 6'h01);
                    if (bit_reg == adc_serial_pkg::cnt_t'(
                            adc_serial_pkg::INSTR_BITS - 1)) begin
                        rd_next = instr_shift[adc_serial_pkg::INSTR_RD_BIT];
                        nbits_next = data_bits(instr_shift);
                        shift_next = output_data_register;
                        bit_next = 6'h00;
                        cnt_next = 6'h00;
                        st_next = adc_serial_pkg::ST_GAP;
                    end
                end
            end
            adc_serial_pkg::ST_GAP: begin
                if (master_s && cnt_reg == adc_serial_pkg::C_M_INSTR_REL) begin
                    oe_next = 1'b0;
                end
                if (!master_s && cnt_reg == adc_serial_pkg::C_S_INSTR_REL) begin
                    oe_next = 1'b0;
                end
                if (rd_reg && ((master_s &&
                        cnt_reg == adc_serial_pkg::C_M_DRIVE) ||
                        (!master_s &&
                        cnt_reg == adc_serial_pkg::C_S_DRIVE))) begin
                    oe_next = 1'b1;
                    sdo_next = shift_reg[adc_serial_pkg::WORD_W-1];
                end
                if (master_s && cnt_reg == adc_serial_pkg::C_M_GAP) begin
                    sclk_next = 1'b1;
                    phase_next = 6'h00;
                    st_next = adc_serial_pkg::ST_DATA;
                end else if (!master_s && pin_s.sclk && !sclk_prev_reg) begin
                    st_next = adc_serial_pkg::ST_DATA;
                end
            end
            adc_serial_pkg::ST_DATA: begin
                if (rise && rd_reg) begin
                    sdo_next = shift_reg[adc_serial_pkg::WORD_W-1];
                end
                if (fall) begin
                    shift_next = {shift_reg[adc_serial_pkg::WORD_W-2:0],
                                  pin_s.sdio};
                    bit_next = adc_serial_pkg::cnt_t'(bit_reg + 6'h01);
                    if (bit_reg == adc_serial_pkg::cnt_t'(
                            nbits_reg - 6'h01)) begin
                        cnt_next = 6'h00;
                        st_next = adc_serial_pkg::ST_TAIL;
                    end
                end
            end
            adc_serial_pkg::ST_TAIL: begin
                if (master_s && cnt_reg == adc_serial_pkg::C_M_DATA_REL) begin
                    oe_next = 1'b0;
                end
                if (!master_s && cnt_reg == adc_serial_pkg::C_S_DATA_REL) begin
                    oe_next = 1'b0;
                end
                if ((master_s && cnt_reg == adc_serial_pkg::C_M_RDY_RISE) ||
                    (!master_s &&
                    cnt_reg == adc_serial_pkg::C_S_RDY_RISE)) begin
                    ready_n_next = 1'b1;
                    wr_vld_next = !rd_reg;
                    rd_next = 1'b0;
                    st_next = adc_serial_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next = adc_serial_pkg::ST_IDLE;
            end
        endcase

        // a long sync pulse aborts the frame and releases ready, clock and data line
        if (sync_hold) begin
            st_next = adc_serial_pkg::ST_IDLE;
            ready_n_next = 1'b1;
            oe_next = 1'b0;
            sclk_next = 1'b0;
            rd_next = 1'b0;
            wr_vld_next = 1'b0;
        end
    end

    always_ff @(posedge master_clock_in) begin
        if (!link_rst_b) begin
            st_reg <= adc_serial_pkg::ST_IDLE;
            cnt_reg <= 6'h00;
            phase_reg <= 6'h00;
            bit_reg <= 6'h00;
            nbits_reg <= 6'h00;
            cs_lo_reg <= 6'h00;
            sync_lo_reg <= 6'h00;
            instruction_byte_reg <= 8'h00;
            output_data_register <= adc_serial_pkg::WORD_RESET;
            shift_reg <= adc_serial_pkg::WORD_RESET;
            rd_reg <= 1'b0;
            sclk_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            sdo_reg <= 1'b0;
            oe_reg <= 1'b0;
            ready_n_reg <= 1'b1;
            wr_vld_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            bit_reg <= bit_next;
            nbits_reg <= nbits_next;
            cs_lo_reg <= cs_lo_next;
            sync_lo_reg <= sync_lo_next;
            instruction_byte_reg <= instr_next;
            output_data_register <= dor_next;
            shift_reg <= shift_next;
            rd_reg <= rd_next;
            sclk_reg <= sclk_next;
            sclk_prev_reg <= sclk_prev_next;
            sdo_reg <= sdo_next;
            oe_reg <= oe_next;
            ready_n_reg <= ready_n_next;
            wr_vld_reg <= wr_vld_next;
        end
    end

    // select does not gate the data line; only the sequence does
    always_comb begin
        pins_out.sclk_o = sclk_reg;
        pins_out.sclk_oe = master_s;
        pins_out.sdio_o = sdo_reg;
        pins_out.sdio_oe = oe_reg;
        pins_out.conversion_ready_n = ready_n_reg;
    end

endmodule : adc_serial_seq

// ### adc_serial_pkg.sv
// shared constants, pin carriers and state encoding for the serial port
// sequencer; every interval is counted in master clock periods
package adc_serial_pkg;

    // one master clock period per sequencer cycle
    localparam int XIN_PER_CYCLE = 1;
    // pins pass a two-flop synchroniser before the sequencer sees them
    localparam int SYNC_LAT = 2;
    // host pin edge to a slave-timed action: sync, edge detect, state reg
    localparam int S_LAG = SYNC_LAT + 2;

    // intervals in master clock periods
    localparam int T_SCLK_HALF = 2;
    localparam int T_RDY_FIRST = 12;
    localparam int T_CS_FIRST = 11;
    localparam int T_M_GAP = 10;
    localparam int T_M_RDY_RISE = 6;
    localparam int T_S_RDY_RISE = 9;
    localparam int T_M_INSTR_REL = 4;
    localparam int T_S_INSTR_REL = 7;
    localparam int T_DRIVE_LEAD = 4;
    localparam int T_S_GAP_MIN = 13;
    localparam int T_M_DATA_REL = 2;
    localparam int T_S_DATA_REL = 5;
    localparam int T_SYNC_MIN = 21;

    localparam int CNT_W = 6;
    typedef logic [CNT_W-1:0] cnt_t;

    // compare values: a register set when cnt equals C_x acts one edge later
    localparam cnt_t C_HALF = cnt_t'(T_SCLK_HALF * XIN_PER_CYCLE - 1);
    localparam cnt_t C_RDY_FIRST = cnt_t'(T_RDY_FIRST * XIN_PER_CYCLE - 1);
    localparam cnt_t C_CS_FIRST =
        cnt_t'(T_CS_FIRST * XIN_PER_CYCLE - SYNC_LAT);
    localparam cnt_t C_M_GAP = cnt_t'(T_M_GAP * XIN_PER_CYCLE - 1);
    localparam cnt_t C_M_DRIVE =
        cnt_t'((T_M_GAP - T_DRIVE_LEAD) * XIN_PER_CYCLE - 1);
    localparam cnt_t C_S_DRIVE =
        cnt_t'((T_S_GAP_MIN - T_DRIVE_LEAD) * XIN_PER_CYCLE - S_LAG);
    localparam cnt_t C_M_INSTR_REL = cnt_t'(T_M_INSTR_REL * XIN_PER_CYCLE - 1);
    localparam cnt_t C_S_INSTR_REL =
        cnt_t'(T_S_INSTR_REL * XIN_PER_CYCLE - S_LAG);
    localparam cnt_t C_M_DATA_REL = cnt_t'(T_M_DATA_REL * XIN_PER_CYCLE - 1);
    localparam cnt_t C_S_DATA_REL =
        cnt_t'(T_S_DATA_REL * XIN_PER_CYCLE - S_LAG);
    localparam cnt_t C_M_RDY_RISE = cnt_t'(T_M_RDY_RISE * XIN_PER_CYCLE - 1);
    localparam cnt_t C_S_RDY_RISE =
        cnt_t'(T_S_RDY_RISE * XIN_PER_CYCLE - S_LAG);
    localparam cnt_t C_SYNC_MIN = cnt_t'(T_SYNC_MIN * XIN_PER_CYCLE);
    localparam cnt_t C_MAX = 6'h3f;

    // instruction byte layout
    localparam int INSTR_BITS = 8;
    localparam int INSTR_RD_BIT = 7;
    localparam int INSTR_LEN_LSB = 0;
    localparam int INSTR_LEN_W = 2;

    localparam int WORD_W = 32;
    typedef logic [WORD_W-1:0] word_t;
    localparam word_t WORD_RESET = 32'h0000_0000;

    typedef struct packed {
        logic sclk;
        logic sdio;
        logic cs_n;
        logic sync_n;
    } pin_in_t;

    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic sdio_o;
        logic sdio_oe;
        logic conversion_ready_n;
    } pin_out_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_INSTR,
        ST_GAP,
        ST_DATA,
        ST_TAIL
    } seq_state_t;

endpackage : adc_serial_pkg

// ### level_sync.sv
// two-flop synchroniser for levels entering a clock domain
// assumes inputs change no faster than the destination clock can sample
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic clk,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // no reset: this also carries the reset level itself
    always_ff @(posedge clk) begin
        meta_reg <= d;
        q_reg <= meta_reg;
    end

    assign q = q_reg;

endmodule : level_sync

// ### word_xfer.sv
// toggle handshake carrying one word between unrelated clocks
// assumes the source spaces its strobes by several destination cycles
`timescale 1ns/1ps
module word_xfer (
    // source side
    input wire logic src_clk,
    input wire logic src_rst_b,
    input wire logic src_valid,
    input wire adc_serial_pkg::word_t src_word,
    // destination side
    input wire logic dst_clk,
    input wire logic dst_rst_b,
    output logic dst_valid,
    output adc_serial_pkg::word_t dst_word
);

    adc_serial_pkg::word_t hold_reg, hold_next;
    logic tgl_reg, tgl_next;
    logic tgl_s;
    logic prev_reg, prev_next;
    logic vld_reg, vld_next;
    adc_serial_pkg::word_t out_reg, out_next;

    always_comb begin
        hold_next = src_valid ? src_word : hold_reg;
        tgl_next = src_valid ? ~tgl_reg : tgl_reg;
    end

    always_ff @(posedge src_clk) begin
        if (!src_rst_b) begin
            hold_reg <= adc_serial_pkg::WORD_RESET;
            tgl_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            tgl_reg <= tgl_next;
        end
    end

    level_sync #(.W(1)) u_tgl_sync (
        .clk(dst_clk),
        .d(tgl_reg),
        .q(tgl_s)
    );

    // hold word is stable for the whole synchroniser delay
    always_comb begin
        prev_next = tgl_s;
        vld_next = tgl_s ^ prev_reg;
        out_next = (tgl_s ^ prev_reg) ? hold_reg : out_reg;
    end

    always_ff @(posedge dst_clk) begin
        if (!dst_rst_b) begin
            prev_reg <= 1'b0;
            vld_reg <= 1'b0;
            out_reg <= adc_serial_pkg::WORD_RESET;
        end else begin
            prev_reg <= prev_next;
            vld_reg <= vld_next;
            out_reg <= out_next;
        end
    end

    assign dst_valid = vld_reg;
    assign dst_word = out_reg;

endmodule : word_xfer

// ### adc_serial_monitor.sv
// timing checker for the serial port pins of the sequencer
// assumes pin outputs are registered on master_clock_in
`timescale 1ns/1ps
module adc_serial_monitor (
    // reset and link clock
    input wire logic rst_b,
    input wire logic master_clock_in,
    // serial pins
    input wire adc_serial_pkg::pin_in_t pins_in,
    input wire adc_serial_pkg::pin_out_t pins_out
);
    logic sclk_d_reg;
    logic [9:0] fall_reg;
    logic [5:0] fcnt_reg;
    logic m_mode;
    logic sclk_now;
    logic fall_now;
    logic instr_end;
    assign m_mode = pins_out.sclk_oe;
    assign sclk_now = m_mode ? pins_out.sclk_o : pins_in.sclk;
    assign fall_now = sclk_d_reg & ~sclk_now;
    assign instr_end = fall_now && fcnt_reg == 6'h07;
    // fall history: bit k marks a serial clock fall k+1 cycles ago
    always_ff @(posedge master_clock_in) begin
        sclk_d_reg <= sclk_now;
        fall_reg <= {fall_reg[8:0], fall_now};
        fcnt_reg <= pins_out.conversion_ready_n ? 6'h00 :
            fcnt_reg + 6'(fall_now);
    end
    default clocking @(posedge master_clock_in); endclocking
    default disable iff (!rst_b);
    sequence hi_two;
        pins_out.sclk_o ##1 pins_out.sclk_o ##1 !pins_out.sclk_o;
    endsequence
    sequence lo_ten;
        !pins_out.sclk_o [*8] ##1 !pins_out.sclk_o [*2]
        ##1 pins_out.sclk_o;
    endsequence
    sclk_high_a: assert property (
        m_mode && $rose(pins_out.sclk_o) |-> hi_two)
        else $error("serial clock high phase not two periods");
    sclk_low_a: assert property (
        m_mode && $fell(pins_out.sclk_o) |-> !pins_out.sclk_o [*2])
        else $error("serial clock low phase too short");
    rdy_first_a: assert property (m_mode && !pins_in.cs_n &&
        $fell(pins_out.conversion_ready_n) && !$past(pins_in.cs_n, 8)
        |-> !pins_out.sclk_o [*8] ##1 !pins_out.sclk_o [*4]
        ##1 pins_out.sclk_o)
        else $error("first clock not twelve after ready");
    cs_first_a: assert property (m_mode && $fell(pins_in.cs_n) &&
        !pins_out.conversion_ready_n |->
        !pins_out.sclk_o [*8] ##[3:5] $rose(pins_out.sclk_o))
        else $error("first clock not ten to twelve after select");
    gap_len_a: assert property (m_mode && instr_end |-> lo_ten)
        else $error("instruction to data gap not ten");
    instr_rel_a: assert property (m_mode && instr_end |->
        !pins_out.sdio_oe [*6])
        else $error("data line driven too soon after instruction");
    drive_lead_a: assert property (
        m_mode && $rose(pins_out.sdio_oe) |->
        !pins_out.sclk_o [*4] ##1 pins_out.sclk_o)
        else $error("drive lead before first data clock not four");
    data_rel_a: assert property (m_mode && $fell(pins_out.sdio_oe) |->
        fall_reg[1])
        else $error("master data release not two after last fall");
    rdy_rise_a: assert property (m_mode && pins_in.sync_n &&
        $rose(pins_out.conversion_ready_n) |-> fall_reg[5])
        else $error("master ready rise not six after last fall");
    s_rdy_rise_a: assert property (!m_mode && pins_in.sync_n &&
        $rose(pins_out.conversion_ready_n) |-> |fall_reg[9:7])
        else $error("slave ready rise outside eight to ten");
    s_data_rel_a: assert property (!m_mode && pins_in.sync_n &&
        $fell(pins_out.sdio_oe) |-> |fall_reg[5:3])
        else $error("slave data release outside four to six");
endmodule : adc_serial_monitor

bind adc_serial_seq adc_serial_monitor mon (.rst_b(rst_b),
    .master_clock_in(master_clock_in), .pins_in(pins_in),
    .pins_out(pins_out));

// ### host_model.sv
// serial host: clock in slave mode, instruction and data, select, sync
// assumes the device pins and the link clock; acts 1 ns after each edge
`timescale 1ns/1ps
module host_model (
    // link clock
    input wire logic master_clock_in,
    // device pins
    input wire adc_serial_pkg::pin_out_t pins_out,
    output adc_serial_pkg::pin_in_t pins_in
);
    logic sclk_reg = 1'b0;
    logic cs_n_reg = 1'b0;
    logic sync_n_reg = 1'b1;
    logic hd_reg = 1'b0;
    logic hoe_reg = 1'b0;
    logic last_reg = 1'b0;
    int herr = 0;
    // released line flips so a stale level can never pass for data
    assign pins_in.sdio = pins_out.sdio_oe ? pins_out.sdio_o :
        hoe_reg ? hd_reg : ~last_reg;
    assign pins_in.sclk = sclk_reg;
    assign pins_in.cs_n = cs_n_reg;
    assign pins_in.sync_n = sync_n_reg;
    always @(posedge master_clock_in) last_reg <= pins_in.sdio;

    task automatic tick(input int n);
        repeat (n) @(posedge master_clock_in);
        #1;
    endtask : tick

    task automatic cs_level(input logic v);
        cs_n_reg <= v;
        tick(12);
    endtask : cs_level

    task automatic bit_clk(input logic slv, output logic smp);
        int k;
        if (slv) begin
            sclk_reg <= 1'b1;
            tick(5);
            smp = pins_in.sdio;
            sclk_reg <= 1'b0;
            tick(5);
        end else begin
            for (k = 0; k < 99 && pins_out.sclk_o !== 1'b1; k++) tick(1);
            for (k = 0; k < 99 && pins_out.sclk_o !== 1'b0; k++) tick(1);
            if (k == 99) herr++;
            smp = pins_in.sdio;
        end
    endtask : bit_clk

    task automatic frame(input logic slv, input logic use_cs,
        input logic [7:0] ins, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        int nb;
        logic s;
        nb = 8 * (ins[1:0] + 1);
        rd = '0;
        for (k = 0; k < 999 && pins_out.conversion_ready_n !== 1'b0; k++)
            tick(1);
        if (k == 999) herr++;
        if (use_cs) begin
            tick(3);
            cs_n_reg <= 1'b0;
        end
        if (slv) tick(11);
        hoe_reg <= 1'b1;
        for (k = 7; k >= 0; k--) begin
            hd_reg <= ins[k];
            bit_clk(slv, s);
        end
        hoe_reg <= ~ins[7];
        if (slv) tick(8);
        for (k = nb - 1; k >= 0; k--) begin
            hd_reg <= wd[k];
            bit_clk(slv, s);
            rd[k] = s;
        end
        hoe_reg <= 1'b0;
        for (k = 0; k < 99 && pins_out.conversion_ready_n !== 1'b1; k++)
            tick(1);
        if (k == 99) herr++;
        tick(2);
        if (use_cs) cs_n_reg <= 1'b1;
        tick(41);
    endtask : frame

    task automatic sync_pulse(input int n);
        sync_n_reg <= 1'b0;
        tick(n);
        sync_n_reg <= 1'b1;
        tick(4);
    endtask : sync_pulse
endmodule : host_model

// ### tb_top.sv
// self-checking bench: core side driven here, pins by the host model
// assumes a 50 MHz core clock and an unrelated 12 ns link clock
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic master_clock_in = 1'b0;
    logic rst_b = 1'b0;
    logic master_mode = 1'b1;
    logic result_valid = 1'b0;
    adc_serial_pkg::word_t result_word = '0;
    logic write_valid;
    adc_serial_pkg::word_t write_word;
    adc_serial_pkg::pin_in_t pins_in;
    adc_serial_pkg::pin_out_t pins_out;
    adc_serial_pkg::word_t got_w = '0;
    logic [31:0] rd;
    int n_fail = 0;
    int n_tests = 0;

    initial forever #10 core_clk = ~core_clk;
    initial begin
        #3.7;
        forever #6 master_clock_in = ~master_clock_in;
    end
    adc_serial_seq dut (.core_clk(core_clk), .rst_b(rst_b),
        .master_clock_in(master_clock_in), .master_mode(master_mode),
        .result_valid(result_valid), .result_word(result_word),
        .write_valid(write_valid), .write_word(write_word),
        .pins_in(pins_in), .pins_out(pins_out));
    host_model host (.master_clock_in(master_clock_in),
        .pins_out(pins_out), .pins_in(pins_in));
    always @(posedge core_clk) if (write_valid === 1'b1) got_w <= write_word;

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic push(input logic [31:0] w, input logic m);
        @(posedge core_clk);
        master_mode <= m;
        result_valid <= 1'b1;
        result_word <= w;
        @(posedge core_clk);
        result_valid <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : push

    task automatic stop_test;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic t_master;
        push(32'ha5c3_0f96, 1'b1);
        host.frame(1'b0, 1'b0, 8'h80, 32'h0, rd);
        check(rd[7:0] === 8'ha5, "master read bits");
        host.cs_level(1'b1);
        push(32'h1234_5678, 1'b1);
        host.frame(1'b0, 1'b1, 8'h01, 32'h0000_b2d4, rd);
        // upper half keeps the unshifted low bits of the held result
        check(got_w === 32'h5678_b2d4, "master write word");
        $display("done master frames");
    endtask : t_master

    task automatic t_slave;
        host.frame(1'b1, 1'b1, 8'h02, 32'h0069_1e2b, rd);
        check(got_w === 32'h0069_1e2b, "slave write word");
        host.cs_level(1'b0);
        push(32'h3c96_e187, 1'b0);
        fork
            host.frame(1'b1, 1'b0, 8'h83, 32'h0, rd);
        join_none
        repeat (150) @(posedge core_clk);
        push(32'h0f0f_f0f0, 1'b0);
        wait fork;
        check(rd === 32'h3c96_e187, "slave read kept old word");
        $display("done slave frames");
    endtask : t_slave

    task automatic t_sync;
        push(32'h5a5a_a5a5, 1'b0);
        host.sync_pulse(10);
        check(pins_out.conversion_ready_n === 1'b0, "short sync");
        host.sync_pulse(25);
        check(pins_out.conversion_ready_n === 1'b1, "sync abort");
        check(pins_out.sdio_oe === 1'b0, "sync release");
        $display("done sync");
    endtask : t_sync

    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge core_clk);
        t_master();
        push(32'h0, 1'b0);
        t_slave();
        t_sync();
        check(host.herr == 0, "host wait ran out");
        stop_test();
    end
endmodule : tb_top
